// *** rtl/pipe_ctrl_pkg.sv ***
// shared constants and types for the scalar pipeline control
package pipe_ctrl_pkg;
  localparam int              REG_W         = 4;
  localparam int              NUM_REGS      = 16;
  localparam int              COMPACT_REG_W = 3;
  localparam int              TARGET_W      = 32;
  localparam int              MAC_STAGES    = 5;
  localparam logic [2:0]      MAC_DONE_MIN  = 3'h2;
  localparam logic [2:0]      MAC_DONE_MAX  = 3'h5;
  localparam logic [2:0]      MAC_COMMIT    = 3'h3;
  localparam int              FRONT_STAGES  = 4;  // fetch x2, decode, operand read
  localparam int              MAIN_STAGES   = 7;

  typedef enum logic [2:0] {
    KIND_ALU, KIND_LOAD, KIND_STORE, KIND_MUL, KIND_BRANCH, KIND_BX
  } kind_t;

  typedef enum logic [1:0] {FWD_FILE, FWD_STATE_EXEC, FWD_WRITEBACK} fwd_t;

  typedef struct packed {
    logic             valid;
    kind_t            kind;
    logic             has_dst;
    logic             use1;
    logic             use2;
    logic [REG_W-1:0] dst;
    logic [REG_W-1:0] src1;
    logic [REG_W-1:0] src2;
    logic [2:0]       mac_done;
    logic             expanded;
    fwd_t             fwd1;
    fwd_t             fwd2;
  } instr_t;
endpackage : pipe_ctrl_pkg

// *** rtl/register_scoreboard.sv ***
// pending-destination tracker for load and multiply results
`timescale 1ns/1ps
`default_nettype none
module register_scoreboard
  import pipe_ctrl_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                set_valid,
  input  wire logic [REG_W-1:0]    set_reg,
  input  wire logic                clr_a_valid,
  input  wire logic [REG_W-1:0]    clr_a_reg,
  input  wire logic                clr_b_valid,
  input  wire logic [REG_W-1:0]    clr_b_reg,
  input  wire logic                clr_c_valid,
  input  wire logic [REG_W-1:0]    clr_c_reg,
  output logic [NUM_REGS-1:0]      busy
);
  // one pending bit per register; a new set wins over a return
  genvar r;
  generate
    for (r = 0; r < NUM_REGS; r++) begin : g_bit
      logic set_hit;
      logic clr_hit;
      assign set_hit = set_valid && (set_reg == REG_W'(r));
      assign clr_hit = (clr_a_valid && (clr_a_reg == REG_W'(r)))
                    || (clr_b_valid && (clr_b_reg == REG_W'(r)))
                    || (clr_c_valid && (clr_c_reg == REG_W'(r)));
      always_ff @(posedge clock) begin
        if (rst) begin
          busy[r] <= 1'b0;
        end else if (set_hit) begin
          busy[r] <= 1'b1;
        end else if (clr_hit) begin
          busy[r] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : register_scoreboard
`default_nettype wire

// *** rtl/scalar_superpipeline_control.sv ***
// issue, stall, routing and flush control of the seven-stage pipeline
`timescale 1ns/1ps
`default_nettype none
// Operation
// - seven main stages from fetch to writeback
// - mispredicted branch loses four cycles
// - decode and operand read take two cycles
// - one in-order issue per cycle
// - every stage one cycle except multiplier
// - scoreboard only load and multiply destinations
// - alu destinations are bypassed, not scoreboarded
// - stall on pending load or multiply register
// - no dependency means no stall, except a multiply waiting for multiplier admission
// - completion may be out of order
// - the three pipes run independently
// - forward results from several producers
// - operand read feeds multiplier or alu only
// - loads and stores enter memory pipe
// - branch exchange flushes, never predicted
// - compact instructions expanded at decode
// - multiplier writeback in stages two to five
// - pipes hold different instructions together
// - two cache stages plus writeback, five multiplier
// - mismatch at alu execute flushes and redirects
// - at most two multiplier occupants
// - multiplier stage three onward is committed
module scalar_superpipeline_control
  import pipe_ctrl_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                compact_mode,
  input  wire logic                in_valid,
  input  wire logic [2:0]          in_kind,
  input  wire logic                in_has_dst,
  input  wire logic                in_use1,
  input  wire logic                in_use2,
  input  wire logic [REG_W-1:0]    in_dst,
  input  wire logic [REG_W-1:0]    in_src1,
  input  wire logic [REG_W-1:0]    in_src2,
  input  wire logic [2:0]          in_mac_done,
  input  wire logic                x1_mismatch,
  input  wire logic [TARGET_W-1:0] x1_target,
  input  wire logic                dcache_hit,
  input  wire logic                load_return_valid,
  input  wire logic [REG_W-1:0]    load_return_dst,
  output logic                     fetch_ready_reg,
  output logic                     pipe_stall_reg,
  output logic                     redirect_valid_reg,
  output logic [TARGET_W-1:0]      redirect_target_reg,
  output logic                     predictor_update_reg,
  output fwd_t                     x1_fwd_sel1,
  output fwd_t                     x1_fwd_sel2,
  output logic                     main_wb_valid_reg,
  output logic [REG_W-1:0]         main_wb_dst_reg,
  output logic                     mem_wb_valid_reg,
  output logic [REG_W-1:0]         mem_wb_dst_reg,
  output logic                     mac_wb_valid_reg,
  output logic [REG_W-1:0]         mac_wb_dst_reg
);
  instr_t              skid_reg;
  instr_t              f1_reg;
  instr_t              f2_reg;
  instr_t              id_reg;
  instr_t              rf_reg;
  instr_t              x1_reg;
  instr_t              x2_reg;
  instr_t              d1_reg;
  instr_t              d2_reg;
  instr_t              m_reg [1:MAC_STAGES];
  instr_t              incoming;
  instr_t              fetch_word;
  logic [NUM_REGS-1:0] busy;
  logic [MAC_STAGES:2] mac_arrive;
  logic                take_in;
  logic                hazard;
  logic                mac_ok;
  logic                stall;
  logic                flush;
  logic                issue_main;
  logic                issue_mac;
  logic [2:0]          mac_occ;
  logic [REG_W-1:0]    mac_arrive_dst;

  // decode-time expansion of compact encodings and clamp of multiplier length
  function automatic instr_t expand(input instr_t raw, input logic compact);
    instr_t e;
    e = raw;
    if (compact && raw.valid) begin
      e.dst      = REG_W'(raw.dst[COMPACT_REG_W-1:0]);
      e.src1     = REG_W'(raw.src1[COMPACT_REG_W-1:0]);
      e.src2     = REG_W'(raw.src2[COMPACT_REG_W-1:0]);
      e.expanded = 1'b1;
    end
    if (e.mac_done < MAC_DONE_MIN) e.mac_done = MAC_DONE_MIN;
    if (e.mac_done > MAC_DONE_MAX) e.mac_done = MAC_DONE_MAX;
    return e;
  endfunction : expand

  // bypass source for an operand, youngest alu producer first
  function automatic fwd_t fwd_for(input logic [REG_W-1:0] r);
    if (x1_reg.valid && x1_reg.kind == KIND_ALU && x1_reg.has_dst && x1_reg.dst == r)
      return FWD_STATE_EXEC;
    if (x2_reg.valid && x2_reg.kind == KIND_ALU && x2_reg.has_dst && x2_reg.dst == r)
      return FWD_WRITEBACK;
    return FWD_FILE;
  endfunction : fwd_for

  // descriptor offered by the fetch unit
  always_comb begin
    incoming          = '0;
    incoming.valid    = 1'b1;
    incoming.kind     = kind_t'(in_kind);
    incoming.has_dst  = in_has_dst;
    incoming.use1     = in_use1;
    incoming.use2     = in_use2;
    incoming.dst      = in_dst;
    incoming.src1     = in_src1;
    incoming.src2     = in_src2;
    incoming.mac_done = in_mac_done;
  end

  assign take_in    = in_valid && fetch_ready_reg;
  assign fetch_word = skid_reg.valid ? skid_reg : (take_in ? incoming : '0);

  // operand-read dependency check against pending load/multiply results
  assign hazard = (rf_reg.use1 && busy[rf_reg.src1])
               || (rf_reg.use2 && busy[rf_reg.src2])
               || (rf_reg.has_dst && busy[rf_reg.dst]);

  // multiplier admission: all occupants in their last stage, or the single other one reaches its last stage next cycle
  always_comb begin
    logic [2:0] cont;
    logic       soon;
    cont    = 3'h0;
    soon    = 1'b0;
    mac_occ = 3'h0;
    for (int k = 1; k <= MAC_STAGES; k++) begin
      if (m_reg[k].valid) begin
        mac_occ = mac_occ + 3'h1;
        if (m_reg[k].mac_done != 3'(k)) begin
          cont = cont + 3'h1;
          if (m_reg[k].mac_done == 3'(k + 1)) soon = 1'b1;
        end
      end
    end
    mac_ok = (cont == 3'h0) || (cont == 3'h1 && soon);
  end

  assign stall = rf_reg.valid && (hazard || (rf_reg.kind == KIND_MUL && !mac_ok));
  assign flush = x1_reg.valid
              && ((x1_reg.kind == KIND_BRANCH && x1_mismatch) || x1_reg.kind == KIND_BX);
  assign issue_main = rf_reg.valid && !stall && !flush && rf_reg.kind != KIND_MUL;
  assign issue_mac  = rf_reg.valid && !stall && !flush && rf_reg.kind == KIND_MUL;

  // front stages freeze on stall and empty on flush
  always_ff @(posedge clock) begin
    if (rst || flush) begin
      f1_reg <= '0;
      f2_reg <= '0;
      id_reg <= '0;
      rf_reg <= '0;
    end else if (!stall) begin
      f1_reg <= fetch_word;
      f2_reg <= f1_reg;
      id_reg <= f2_reg;
      rf_reg <= expand(id_reg, compact_mode);
    end
  end

  // one-entry skid catches the word offered while a stall begins
  always_ff @(posedge clock) begin
    if (rst || flush) begin
      skid_reg <= '0;
    end else if (!stall) begin
      skid_reg <= '0;
    end else if (take_in) begin
      skid_reg <= incoming;
    end
  end

  // fetch handshake, dropped while the skid is or becomes full
  always_ff @(posedge clock) begin
    if (rst) begin
      fetch_ready_reg <= 1'b1;
    end else begin
      fetch_ready_reg <= flush || !(stall && (skid_reg.valid || take_in));
    end
  end

  // main execution path: alu execute, state execute, writeback
  always_ff @(posedge clock) begin
    if (rst) begin
      x1_reg <= '0;
      x2_reg <= '0;
    end else begin
      x1_reg <= '0;
      if (issue_main) begin
        x1_reg      <= rf_reg;
        x1_reg.fwd1 <= fwd_for(rf_reg.src1);
        x1_reg.fwd2 <= fwd_for(rf_reg.src2);
      end
      x2_reg <= x1_reg;
    end
  end

  // main writeback of alu results
  always_ff @(posedge clock) begin
    if (rst) begin
      main_wb_valid_reg <= 1'b0;
      main_wb_dst_reg   <= '0;
    end else begin
      main_wb_valid_reg <= x2_reg.valid && x2_reg.kind == KIND_ALU && x2_reg.has_dst;
      main_wb_dst_reg   <= x2_reg.dst;
    end
  end

  assign x1_fwd_sel1 = x1_reg.fwd1;
  assign x1_fwd_sel2 = x1_reg.fwd2;

  // memory path: two cache stages then cache writeback
  always_ff @(posedge clock) begin
    if (rst) begin
      d1_reg           <= '0;
      d2_reg           <= '0;
      mem_wb_valid_reg <= 1'b0;
      mem_wb_dst_reg   <= '0;
    end else begin
      d1_reg <= (x1_reg.kind == KIND_LOAD || x1_reg.kind == KIND_STORE) ? x1_reg : '0;
      d2_reg <= d1_reg;
      mem_wb_valid_reg <= d2_reg.valid && d2_reg.kind == KIND_LOAD
                       && d2_reg.has_dst && dcache_hit;
      mem_wb_dst_reg   <= d2_reg.dst;
    end
  end

  // multiplier entry; later stages are never touched by a flush
  always_ff @(posedge clock) begin
    if (rst) begin
      m_reg[1] <= '0;
    end else begin
      m_reg[1] <= issue_mac ? rf_reg : '0;
    end
  end

  genvar k;
  generate
    for (k = 2; k <= MAC_STAGES; k++) begin : g_mac
      assign mac_arrive[k] = m_reg[k-1].valid && m_reg[k-1].mac_done == 3'(k);
      always_ff @(posedge clock) begin
        if (rst) begin
          m_reg[k] <= '0;
        end else if (m_reg[k-1].valid && m_reg[k-1].mac_done != 3'(k - 1)) begin
          m_reg[k] <= m_reg[k-1];
        end else begin
          m_reg[k] <= '0;
        end
      end
    end
  endgenerate

  always_comb begin
    mac_arrive_dst = '0;
    for (int j = 2; j <= MAC_STAGES; j++) begin
      if (mac_arrive[j]) mac_arrive_dst = m_reg[j-1].dst;
    end
  end

  // multiplier writeback during the completing stage
  always_ff @(posedge clock) begin
    if (rst) begin
      mac_wb_valid_reg <= 1'b0;
      mac_wb_dst_reg   <= '0;
    end else begin
      mac_wb_valid_reg <= |mac_arrive;
      mac_wb_dst_reg   <= mac_arrive_dst;
    end
  end

  register_scoreboard u_scoreboard (
    .clock       (clock),
    .rst         (rst),
    .set_valid   ((issue_main && rf_reg.kind == KIND_LOAD && rf_reg.has_dst)
                  || (issue_mac && rf_reg.has_dst)),
    .set_reg     (rf_reg.dst),
    .clr_a_valid (mac_wb_valid_reg),
    .clr_a_reg   (mac_wb_dst_reg),
    .clr_b_valid (mem_wb_valid_reg),
    .clr_b_reg   (mem_wb_dst_reg),
    .clr_c_valid (load_return_valid),
    .clr_c_reg   (load_return_dst),
    .busy        (busy)
  );

  // redirect to the resolved target and predictor update
  always_ff @(posedge clock) begin
    if (rst) begin
      redirect_valid_reg   <= 1'b0;
      redirect_target_reg  <= '0;
      predictor_update_reg <= 1'b0;
      pipe_stall_reg       <= 1'b0;
    end else begin
      redirect_valid_reg   <= flush;
      predictor_update_reg <= flush && x1_reg.kind == KIND_BRANCH;
      pipe_stall_reg       <= stall;
      if (flush) redirect_target_reg <= x1_target;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_mem_entry;
    x1_reg.valid && (x1_reg.kind == KIND_LOAD || x1_reg.kind == KIND_STORE);
  endsequence
  sequence s_mem_walk;
    d1_reg.valid ##1 d2_reg.valid;
  endsequence

  a_flush_front: assert property (flush |=> !f1_reg.valid && !rf_reg.valid && redirect_valid_reg)
    else $error("front stages not emptied on flush");
  a_flush_penalty: assert property (flush |=> !x1_reg.valid [*4])
    else $error("target reached alu execute before penalty elapsed");
  a_bx_no_update: assert property (x1_reg.valid && x1_reg.kind == KIND_BX |=> redirect_valid_reg && !predictor_update_reg)
    else $error("branch exchange handled as predicted branch");
  a_stall_hazard: assert property (rf_reg.valid && hazard |-> stall)
    else $error("dependent instruction not held");
  a_no_false_stall: assert property (rf_reg.valid && !hazard && rf_reg.kind != KIND_MUL |-> !stall)
    else $error("stall without dependency");
  a_stall_freeze: assert property (stall && !flush |=> $stable(rf_reg) && !x1_reg.valid && !m_reg[1].valid)
    else $error("upstream moved during stall");
  a_single_route: assert property (!(x1_reg.valid && m_reg[1].valid))
    else $error("instruction sent to both paths");
  a_mem_route: assert property (s_mem_entry |=> s_mem_walk)
    else $error("load or store missed the memory path");
  a_mac_capacity: assert property (mac_occ <= 3'h2)
    else $error("more than two multiplier occupants");
  a_mac_commit: assert property (m_reg[3].valid && m_reg[3].mac_done > MAC_COMMIT |=> m_reg[4].valid && m_reg[4].dst == $past(m_reg[3].dst))
    else $error("committed multiply dropped");
  a_mac_wb_time: assert property (issue_mac && rf_reg.mac_done == 3'h2 |=> ##1 mac_wb_valid_reg)
    else $error("short multiply not written in stage two");
  a_alu_not_scored: assert property (issue_main && rf_reg.kind == KIND_ALU && rf_reg.has_dst && !busy[rf_reg.dst] |=> !busy[$past(rf_reg.dst)])
    else $error("alu destination marked pending");
endmodule : scalar_superpipeline_control
`default_nettype wire

// *** tb/cache_far_model.sv ***
// behavioural data cache and refill return path facing the pipeline control
`timescale 1ns/1ps
`default_nettype none
module cache_far_model
  import pipe_ctrl_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             miss_mode,
  input  wire logic             req,
  input  wire logic [REG_W-1:0] req_dst,
  input  wire logic [7:0]       req_delay,
  output logic                  dcache_hit,
  output logic                  load_return_valid,
  output logic [REG_W-1:0]      load_return_dst
);
  logic [7:0]       cnt_reg;
  logic [REG_W-1:0] dst_reg;
  // hit level follows the mode asked by the bench
  assign dcache_hit = !miss_mode;
  // count the refill delay, then hand the missed register back once
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg           <= 8'h0;
      dst_reg           <= '0;
      load_return_valid <= 1'b0;
      load_return_dst   <= '0;
    end else begin
      if (req) begin
        cnt_reg <= req_delay;
        dst_reg <= req_dst;
      end else if (cnt_reg != 8'h0) begin
        cnt_reg <= cnt_reg - 8'h1;
      end
      load_return_valid <= !req && cnt_reg == 8'h1;
      // idle return bus toggles rather than keeping the last register
      load_return_dst   <= (!req && cnt_reg == 8'h1) ? dst_reg : ~load_return_dst;
    end
  end
endmodule : cache_far_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the scalar pipeline control
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pipe_ctrl_pkg::*;
  typedef struct {int lo; int hi; logic [31:0] v; logic x;} note_t;
  logic              clock, rst, compact_mode, in_valid, in_has_dst, in_use1, in_use2;
  logic [2:0]        in_kind, in_mac_done;
  logic [REG_W-1:0]  in_dst, in_src1, in_src2, req_dst, load_return_dst;
  logic              x1_mismatch, dcache_hit, load_return_valid, miss_mode, req;
  logic [TARGET_W-1:0] x1_target, redirect_target_reg;
  logic [7:0]        req_delay;
  logic              fetch_ready_reg, pipe_stall_reg, redirect_valid_reg, predictor_update_reg;
  fwd_t              x1_fwd_sel1, x1_fwd_sel2;
  logic              main_wb_valid_reg, mem_wb_valid_reg, mac_wb_valid_reg;
  logic [REG_W-1:0]  main_wb_dst_reg, mem_wb_dst_reg, mac_wb_dst_reg;
  note_t             q[5][$];
  int                cyc = 0;
  int                n_errors = 0;
  int                n_compared = 0;

  scalar_superpipeline_control i_dut (.clock, .rst, .compact_mode, .in_valid, .in_kind,
    .in_has_dst, .in_use1, .in_use2, .in_dst, .in_src1, .in_src2, .in_mac_done, .x1_mismatch,
    .x1_target, .dcache_hit, .load_return_valid, .load_return_dst, .fetch_ready_reg,
    .pipe_stall_reg, .redirect_valid_reg, .redirect_target_reg, .predictor_update_reg,
    .x1_fwd_sel1, .x1_fwd_sel2, .main_wb_valid_reg, .main_wb_dst_reg, .mem_wb_valid_reg,
    .mem_wb_dst_reg, .mac_wb_valid_reg, .mac_wb_dst_reg);
  cache_far_model i_far (.clock, .rst, .miss_mode, .req, .req_dst, .req_delay, .dcache_hit,
    .load_return_valid, .load_return_dst);

  // free-running clock and edge counter
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // compare an observed result with the oldest note of its pipe
  task automatic take_note(input int p, input string nm, input logic [31:0] s, input logic xs);
    note_t n;
    if (q[p].size() == 0) begin
      check({nm, " unexpected"}, 32'h0, 32'h1);
      return;
    end
    n = q[p].pop_front();
    check(nm, n.v, s);
    check({nm, " cycle"}, 32'h1, 32'(cyc >= n.lo && cyc <= n.hi));
    if (p == 4) check("predictor update", 32'(n.x), 32'(xs));
  endtask : take_note

  // offer one descriptor and wait boundedly until it is taken
  task automatic issue(input kind_t k, input logic [3:0] d, s1, s2, input logic [2:0] dn,
                       output int t);
    int n;
    in_kind = 3'(k);
    in_has_dst = k inside {KIND_ALU, KIND_LOAD, KIND_MUL};
    in_use1 = 1'b1;
    in_use2 = 1'b1;
    in_dst = d;
    in_src1 = s1;
    in_src2 = s2;
    in_mac_done = dn;
    in_valid = 1'b1;
    for (n = 0; n < 100 && fetch_ready_reg !== 1'b1; n++) @(negedge clock);
    if (n == 100) begin
      n_errors++;
      tally_and_finish();
    end
    t = cyc + 1;
    @(negedge clock);
  endtask : issue

  task automatic alu(input logic [3:0] d, s1, s2, e, output int t);
    issue(KIND_ALU, d, s1, s2, 3'h2, t);
    q[0].push_back(note_t'{t + 6, t + 6, 32'(e), 1'b0});
  endtask : alu

  task automatic idle(input int n);
    in_valid = 1'b0;
    repeat (n) @(negedge clock);
  endtask : idle

  // result watcher: every pulse consumes one note
  always @(negedge clock) if (rst === 1'b0) begin
    if (main_wb_valid_reg === 1'b1) take_note(0, "main wb", 32'(main_wb_dst_reg), 1'b0);
    if (mem_wb_valid_reg === 1'b1) take_note(1, "mem wb", 32'(mem_wb_dst_reg), 1'b0);
    if (mac_wb_valid_reg === 1'b1) take_note(2, "mac wb", 32'(mac_wb_dst_reg), 1'b0);
    if (redirect_valid_reg === 1'b1)
      take_note(4, "redirect", redirect_target_reg, predictor_update_reg);
    if (q[3].size() != 0 && cyc == q[3][0].lo)
      take_note(3, "forward", 32'({x1_fwd_sel1, x1_fwd_sel2}), 1'b0);
  end

  initial begin
    int          t, t2, r, i, j;
    logic [3:0]  d;
    logic [31:0] tg;
    rst = 1'b1; compact_mode = 1'b0; in_valid = 1'b0; in_kind = 3'h0; in_has_dst = 1'b0;
    in_use1 = 1'b0; in_use2 = 1'b0; in_dst = 4'h0; in_src1 = 4'h0; in_src2 = 4'h0;
    in_mac_done = 3'h2; x1_mismatch = 1'b0; x1_target = 32'h0; miss_mode = 1'b0;
    req = 1'b0; req_dst = 4'h0; req_delay = 8'h1;
    void'($urandom(4));
    repeat (2) @(negedge clock);
    rst = 1'b0;
    // random back-to-back alu stream never stalls
    for (i = 0; i < 16; i++) begin
      d = 4'($urandom);
      alu(d, 4'($urandom), 4'($urandom), d, t);
    end
    idle(10);
    // bypass selection one and two behind
    alu(4'h1, 4'h8, 4'h9, 4'h1, t);
    alu(4'h2, 4'h1, 4'h9, 4'h2, t);
    q[3].push_back(note_t'{t + 4, t + 4, 32'({FWD_STATE_EXEC, FWD_FILE}), 1'b0});
    alu(4'h3, 4'h8, 4'h1, 4'h3, t);
    q[3].push_back(note_t'{t + 4, t + 4, 32'({FWD_FILE, FWD_WRITEBACK}), 1'b0});
    idle(10);
    // compact descriptors use the low register bits
    compact_mode = 1'b1;
    alu(4'hd, 4'h9, 4'ha, 4'h5, t);
    idle(8);
    compact_mode = 1'b0;
    // load hit, store without writeback, every multiplier completion stage
    issue(KIND_LOAD, 4'h4, 4'h8, 4'h9, 3'h2, t);
    q[1].push_back(note_t'{t + 7, t + 7, 32'h4, 1'b0});
    issue(KIND_STORE, 4'h6, 4'h8, 4'h9, 3'h2, t);
    idle(12);
    for (i = 2; i <= 5; i++) begin
      issue(KIND_MUL, 4'(i + 8), 4'h1, 4'h2, 3'(i), t);
      q[2].push_back(note_t'{t + 3 + i, t + 3 + i, 32'(i + 8), 1'b0});
      idle(10);
    end
    // long multiply, younger alu overtakes, short multiply must wait for admission
    issue(KIND_MUL, 4'ha, 4'h1, 4'h2, 3'h5, t);
    q[2].push_back(note_t'{t + 8, t + 8, 32'ha, 1'b0});
    alu(4'hc, 4'h8, 4'h9, 4'hc, t2);
    issue(KIND_MUL, 4'hb, 4'h1, 4'h2, 3'h2, t2);
    q[2].push_back(note_t'{t + 9, t + 40, 32'hb, 1'b0});
    idle(20);
    // load miss: independent work finishes, consumer waits for the refill
    for (j = 0; j < 2; j++) begin
      miss_mode = 1'b1;
      issue(KIND_LOAD, 4'h5, 4'h8, 4'h9, 3'h2, t);
      r = t + 7 + (j ? 12 : 1);
      alu(4'h6, 4'h8, 4'h9, 4'h6, t2);
      issue(KIND_ALU, 4'h7, 4'h5, 4'h9, 3'h2, t2);
      q[0].push_back(note_t'{r + 2, r + 12, 32'h7, 1'b0});
      in_valid = 1'b0;
      while (cyc < t + 6) @(negedge clock);
      check("pipe stall", 32'h1, 32'(pipe_stall_reg));
      check("fetch ready", 32'h1, 32'(fetch_ready_reg));
      req = 1'b1;
      req_dst = 4'h5;
      req_delay = j ? 8'hc : 8'h1;
      @(negedge clock);
      req = 1'b0;
      miss_mode = 1'b0;
      idle(30);
    end
    // mispredicted branch then branch exchange: wrong path is flushed
    for (j = 0; j < 2; j++) begin
      tg = $urandom;
      x1_mismatch = !j;
      x1_target = tg;
      issue(j ? KIND_BX : KIND_BRANCH, 4'h0, 4'h8, 4'h9, 3'h2, t);
      q[4].push_back(note_t'{t + 5, t + 6, tg, !j});
      issue(KIND_ALU, 4'hf, 4'h8, 4'h9, 3'h2, t2);
      issue(KIND_ALU, 4'hf, 4'h8, 4'h9, 3'h2, t2);
      in_valid = 1'b0;
      for (i = 0; i < 20 && redirect_valid_reg !== 1'b1; i++) @(negedge clock);
      x1_mismatch = 1'b0;
      alu(4'he, 4'h8, 4'h9, 4'he, t);
      idle(12);
    end
    for (i = 0; i < 200 && q[0].size() + q[1].size() + q[2].size() + q[4].size() != 0; i++)
      @(negedge clock);
    check("notes left", 32'h0, 32'(q[0].size() + q[1].size() + q[2].size() + q[4].size()));
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
